// File: hdl/mfi_defines.svh
// offsets, field positions, reset values and timing counts of the contact input decoder
`ifndef MFI_DEFINES_SVH
`define MFI_DEFINES_SVH

// ==========================================================================
// timing
`define CLK_FREQ_MHZ      100
`define TICK_TIME_US      1000
`define TICK_CYCLES       (`TICK_TIME_US * `CLK_FREQ_MHZ)
`define SH_TIME_MS        100
`define SH_TICKS          (`SH_TIME_MS * 1000 / `TICK_TIME_US + 1)
`define DEBOUNCE_TICKS    3

// ==========================================================================
// register byte offsets
`define OFS_CONFIG        8'h00
`define OFS_SECOND_AFN    8'h04
`define OFS_TRIM_LEVEL    8'h08
`define OFS_ES_GAIN       8'h0c
`define OFS_ES_START      8'h10
`define OFS_VREC_TIME     8'h14
`define OFS_FAST_STOP     8'h18
`define OFS_INPUT_VOLT    8'h1c
`define OFS_RT_TIMEOUT    8'h20
`define OFS_STATUS        8'h24
`define OFS_HELD_REF      8'h28
`define OFS_FUNC_BASE     8'h40
`define NUM_PARAMS        9

// ==========================================================================
// field positions
`define CFG_REF_LOCAL     0
`define ST_SET_ERR        0
`define ST_LOCKOUT        1
`define ST_PID_EN         2
`define ST_DC_BRAKE       3
`define ST_EXT_FAULT      4
`define ST_EXT_ALARM      5
`define ST_RT_ACTIVE      6
`define ST_UV_FAULT       7
`define ST_SH_HELD        8
`define ST_ES_ACTIVE      9
`define ST_CONTACTS       16

// ==========================================================================
// reset values
`define RST_CONFIG        16'h0000
`define RST_SECOND_AFN    16'h0000
`define RST_TRIM_LEVEL    16'h0000
`define RST_ES_GAIN       16'h8000
`define RST_ES_START      16'h0000
`define RST_VREC_TIME     16'h0001
`define RST_FAST_STOP     16'h0064
`define RST_INPUT_VOLT    16'h0000
`define RST_RT_TIMEOUT    16'h01f4
`define RST_FUNC_CODE     8'h00
`define VOLT_FULL         16'hffff

// ==========================================================================
// function codes
`define FN_PID_DISABLE    8'h19
`define FN_LOCKOUT        8'h1b
`define FN_TRIM_UP        8'h1c
`define FN_TRIM_DOWN      8'h1d
`define FN_SAMPLE_HOLD    8'h1e
`define FN_TERM_SELECT    8'h1f
`define FN_EXT_FAULT_HI   4'h2
`define FN_PID_I_RESET    8'h30
`define FN_PID_I_HOLD     8'h31
`define FN_DC_BRAKE       8'h60
`define FN_ENERGY_SAVE    8'h63
`define FN_RT_NC          8'h65
`define FN_RT_NO          8'h66
`define EF_BIT_NC         0
`define EF_BIT_RUN_ONLY   1
`define BUS_GAIN_NUM      32'd135
`define BUS_GAIN_DEN      32'd100

`endif

// File: hdl/mfi_pkg.sv
// types of the contact input decoder
package mfi_pkg;

	// ======================================================================
	// bus carrier
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	// ======================================================================
	// control carriers
	typedef enum logic [1:0] {
		EF_RAMP  = 2'b00,
		EF_COAST = 2'b01,
		EF_FAST  = 2'b10,
		EF_ALARM = 2'b11
	} ext_action_t;

	typedef struct packed {
		logic enable;
		logic integ_reset;
		logic integ_hold;
	} pid_ctl_t;

	typedef struct packed {
		logic        fault;
		logic        alarm;
		ext_action_t action;
	} ext_fault_t;

	// ======================================================================
	// state machines
	typedef enum logic [1:0] {
		SH_TRACK = 2'b01,
		SH_HELD  = 2'b10
	} sh_state_t;

	typedef enum logic [2:0] {
		RT_IDLE   = 3'b001,
		RT_ACTIVE = 3'b010,
		RT_FAULT  = 3'b100
	} rt_state_t;

endpackage : mfi_pkg

// File: hdl/multifunction_input_decoder.sv
// contact input function decoder with classic wishbone register slave
`timescale 1ns/1ns
`include "mfi_defines.svh"

// What this block does
// R1 - pid disable contact: open enables pid control, closed disables it
// R2 - lockout contact open: every parameter write is ignored
// R3 - trim up/down contact closed offsets frequency by the trim level
// R4 - trim contacts ignored while reference comes from the local operator
// R5 - sample/hold closed 100ms or more: sample analog reference once, then hold
// R6 - sample/hold closure shorter than 100ms captures nothing
// R7 - terminal select: open uses first analog input, closed uses second
// R8 - fault codes 20-2f: bit0 nc, bit1 run only, bits3:2 action
// R9 - default fault code is normally open, always, ramp to stop
// R10 - terminal select assigned without matching second analog function: setting error
// R11 - integral reset contact: open accumulates, closed forces integral to zero
// R12 - integral hold contact closed freezes the pid integral
// R13 - brake contact while stopped starts dc injection braking
// R14 - run or jog command ends braking and takes priority
// R15 - energy save closed at or above start frequency drops voltage to gain
// R16 - energy save voltage changes ramp by the recovery time
// R17 - ridethrough on power loss: fast-stop decel until restore, else undervoltage fault
// R18 - ridethrough regulates bus voltage to 1.35 times input voltage
// R19 - each slot decodes its code; undocumented codes do nothing
// R20 - each contact sampled synchronously and debounced before use
module multifunction_input_decoder #(
	parameter int NUM_INPUTS     = 8,
	parameter int TICK_CYCLES    = `TICK_CYCLES,
	parameter int SH_TICKS       = `SH_TICKS,
	parameter int DEBOUNCE_TICKS = `DEBOUNCE_TICKS
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire mfi_pkg::wb_req_t        wb_i,
	output logic                         wb_ack_o,
	output logic [31:0]                  wb_dat_o,
	input  wire logic [NUM_INPUTS-1:0]   contacts_i,
	input  wire logic [15:0]             analog1_i,
	input  wire logic [15:0]             analog2_i,
	input  wire logic [15:0]             out_freq_i,
	input  wire logic                    running_i,
	input  wire logic                    run_cmd_i,
	input  wire logic                    jog_cmd_i,
	input  wire logic                    power_loss_i,
	output mfi_pkg::pid_ctl_t            pid_o,
	output mfi_pkg::ext_fault_t          ext_fault_o,
	output logic signed [16:0]           trim_offset_o,
	output logic [15:0]                  freq_ref_o,
	output logic                         dc_brake_o,
	output logic [15:0]                  voltage_level_o,
	output logic                         ridethrough_o,
	output logic [15:0]                  decel_time_o,
	output logic [15:0]                  bus_target_o,
	output logic                         undervoltage_fault_o,
	output logic                         input_setting_error_o,
	output logic                         lockout_o
);
	import mfi_pkg::*;

	initial begin
		if (NUM_INPUTS < 1 || NUM_INPUTS > 8)
			$error("bad NUM_INPUTS");
		if (TICK_CYCLES < 1 || SH_TICKS < 2 || SH_TICKS > 65535)
			$error("bad tick counts");
		if (DEBOUNCE_TICKS < 1 || DEBOUNCE_TICKS > 15)
			$error("bad DEBOUNCE_TICKS");
	end

	// ======================================================================
	// helpers
	// level seen on any slot carrying the given code, closed or open
	function automatic logic any_level(input logic [NUM_INPUTS-1:0][7:0] codes,
		input logic [NUM_INPUTS-1:0] lvl, input logic [7:0] code,
		input logic want_closed);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			if (codes[i] == code && lvl[i] == want_closed)
				hit = 1'b1;
		end
		return hit;
	endfunction : any_level

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [15:0] res;
		res = old;
		if (sel[0])
			res[7:0] = dat[7:0];
		if (sel[1])
			res[15:8] = dat[15:8];
		return res;
	endfunction : merge16

	// ======================================================================
	// declarations
	logic [31:0]                tick_cnt_reg;
	logic                       tick;
	logic [NUM_INPUTS-1:0]      sample_reg;
	logic [NUM_INPUTS-1:0]      level_reg;
	logic [NUM_INPUTS-1:0][7:0] func_reg;
	logic [15:0]                param_reg [`NUM_PARAMS];
	logic                       ack_reg;
	logic [31:0]                rdata_reg;
	logic [31:0]                rdata_next;
	logic                       bus_req;
	logic                       wr_ok;
	logic                       ref_local;
	logic                       term_sel;
	logic [15:0]                ref_selected;
	sh_state_t                  sh_state_reg;
	logic [15:0]                sh_cnt_reg;
	logic [15:0]                held_ref_reg;
	logic                       sh_closed;
	logic                       es_on;
	logic [15:0]                volt_target;
	logic [15:0]                vrec_cnt_reg;
	rt_state_t                  rt_state_reg;
	logic [15:0]                rt_cnt_reg;
	logic                       rt_sel;
	logic                       brake_req;
	logic                       trim_up;
	logic                       trim_down;
	ext_fault_t                 ef_next;
	logic [31:0]                bus_product;
	logic [31:0]                status_word;

	// ======================================================================
	// millisecond tick
	always_ff @(posedge clk_i) begin
		if (rst_i || tick_cnt_reg == 32'(TICK_CYCLES - 1))
			tick_cnt_reg <= 32'h0;
		else
			tick_cnt_reg <= tick_cnt_reg + 32'h1;
	end
	assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

	// ======================================================================
	// contact sampling and debounce
	always_ff @(posedge clk_i) begin
		if (rst_i)
			sample_reg <= '0;
		else
			sample_reg <= contacts_i; // R20
	end

	for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_debounce
		logic [3:0] db_cnt_reg;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				db_cnt_reg   <= 4'h0;
				level_reg[g] <= 1'b0;
			end else if (sample_reg[g] == level_reg[g]) begin
				db_cnt_reg <= 4'h0;
			end else if (tick) begin
				if (db_cnt_reg == 4'(DEBOUNCE_TICKS - 1)) begin
					level_reg[g] <= sample_reg[g]; // R20
					db_cnt_reg   <= 4'h0;
				end else begin
					db_cnt_reg <= db_cnt_reg + 4'h1;
				end
			end
		end
	end

	// ======================================================================
	// wishbone slave
	assign bus_req = wb_i.cyc && wb_i.stb && !ack_reg;
	assign wr_ok   = bus_req && wb_i.we && !lockout_o; // R2

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= bus_req;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			param_reg[0] <= `RST_CONFIG;
			param_reg[1] <= `RST_SECOND_AFN;
			param_reg[2] <= `RST_TRIM_LEVEL;
			param_reg[3] <= `RST_ES_GAIN;
			param_reg[4] <= `RST_ES_START;
			param_reg[5] <= `RST_VREC_TIME;
			param_reg[6] <= `RST_FAST_STOP;
			param_reg[7] <= `RST_INPUT_VOLT;
			param_reg[8] <= `RST_RT_TIMEOUT;
		end else if (wr_ok && wb_i.adr[7:6] == 2'b00 && wb_i.adr[1:0] == 2'b00
			&& wb_i.adr[7:2] < 6'(`NUM_PARAMS)) begin
			param_reg[wb_i.adr[5:2]] <= merge16(param_reg[wb_i.adr[5:2]], wb_i.dat, wb_i.sel);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			func_reg <= {NUM_INPUTS{`RST_FUNC_CODE}};
		end else if (wr_ok && wb_i.adr[7:6] == 2'b01 && wb_i.sel[0]
			&& wb_i.adr[5:2] < 4'(NUM_INPUTS)) begin
			func_reg[wb_i.adr[4:2]] <= wb_i.dat[7:0]; // R19
		end
	end

	always_comb begin
		status_word = 32'h0;
		status_word[`ST_SET_ERR]   = input_setting_error_o;
		status_word[`ST_LOCKOUT]   = lockout_o;
		status_word[`ST_PID_EN]    = pid_o.enable;
		status_word[`ST_DC_BRAKE]  = dc_brake_o;
		status_word[`ST_EXT_FAULT] = ext_fault_o.fault;
		status_word[`ST_EXT_ALARM] = ext_fault_o.alarm;
		status_word[`ST_RT_ACTIVE] = ridethrough_o;
		status_word[`ST_UV_FAULT]  = undervoltage_fault_o;
		status_word[`ST_SH_HELD]   = (sh_state_reg == SH_HELD);
		status_word[`ST_ES_ACTIVE] = es_on;
		status_word[`ST_CONTACTS +: NUM_INPUTS] = level_reg;
	end

	always_comb begin
		rdata_next = 32'h0;
		if (wb_i.adr[1:0] == 2'b00) begin
			if (wb_i.adr[7:6] == 2'b00 && wb_i.adr[7:2] < 6'(`NUM_PARAMS))
				rdata_next = {16'h0, param_reg[wb_i.adr[5:2]]};
			else if (wb_i.adr == `OFS_STATUS)
				rdata_next = status_word;
			else if (wb_i.adr == `OFS_HELD_REF)
				rdata_next = {16'h0, held_ref_reg};
			else if (wb_i.adr[7:6] == 2'b01 && wb_i.adr[5:2] < 4'(NUM_INPUTS))
				rdata_next = {24'h0, func_reg[wb_i.adr[4:2]]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			rdata_reg <= 32'h0;
		else if (bus_req && !wb_i.we)
			rdata_reg <= rdata_next;
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	// ======================================================================
	// level decodes
	assign ref_local = param_reg[0][`CFG_REF_LOCAL];
	assign term_sel  = any_level(func_reg, level_reg, `FN_TERM_SELECT, 1'b1); // R7
	assign sh_closed = any_level(func_reg, level_reg, `FN_SAMPLE_HOLD, 1'b1);
	assign brake_req = any_level(func_reg, level_reg, `FN_DC_BRAKE, 1'b1);
	assign trim_up   = any_level(func_reg, level_reg, `FN_TRIM_UP, 1'b1) && !ref_local; // R3 R4
	assign trim_down = any_level(func_reg, level_reg, `FN_TRIM_DOWN, 1'b1) && !ref_local; // R3 R4
	assign es_on     = any_level(func_reg, level_reg, `FN_ENERGY_SAVE, 1'b1)
		&& out_freq_i >= param_reg[4]; // R15
	assign rt_sel    = any_level(func_reg, level_reg, `FN_RT_NO, 1'b1)
		|| any_level(func_reg, level_reg, `FN_RT_NC, 1'b0); // R17
	assign ref_selected = term_sel ? analog2_i : analog1_i; // R7

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pid_o                 <= '{enable: 1'b1, integ_reset: 1'b0, integ_hold: 1'b0};
			lockout_o             <= 1'b0;
			input_setting_error_o <= 1'b0;
			trim_offset_o         <= 17'sh0;
			dc_brake_o            <= 1'b0;
		end else begin
			pid_o.enable <= !any_level(func_reg, level_reg, `FN_PID_DISABLE, 1'b1); // R1
			pid_o.integ_reset <= any_level(func_reg, level_reg, `FN_PID_I_RESET, 1'b1); // R11
			pid_o.integ_hold <= any_level(func_reg, level_reg, `FN_PID_I_HOLD, 1'b1); // R12
			lockout_o <= any_level(func_reg, level_reg, `FN_LOCKOUT, 1'b0); // R2
			input_setting_error_o <= (any_level(func_reg, level_reg, `FN_TERM_SELECT, 1'b0)
				|| term_sel) && param_reg[1][7:0] != `FN_TERM_SELECT; // R10
			if (trim_up && !trim_down)
				trim_offset_o <= $signed({1'b0, param_reg[2]}); // R3
			else if (trim_down && !trim_up)
				trim_offset_o <= -$signed({1'b0, param_reg[2]}); // R3
			else
				trim_offset_o <= 17'sh0;
			dc_brake_o <= brake_req && !running_i && !run_cmd_i && !jog_cmd_i; // R13 R14
		end
	end

	// ======================================================================
	// external fault decode
	always_comb begin
		ef_next = '{fault: 1'b0, alarm: 1'b0, action: EF_RAMP};
		for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
			if (func_reg[i][7:4] == `FN_EXT_FAULT_HI
				&& (level_reg[i] ^ func_reg[i][`EF_BIT_NC])
				&& (running_i || !func_reg[i][`EF_BIT_RUN_ONLY])) begin // R8
				if (ext_action_t'(func_reg[i][3:2]) == EF_ALARM) begin
					ef_next.alarm = 1'b1; // R8
					if (!ef_next.fault)
						ef_next.action = EF_ALARM; // R8
				end else begin
					ef_next.fault  = 1'b1;
					ef_next.action = ext_action_t'(func_reg[i][3:2]); // R8 R9
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ext_fault_o <= '{fault: 1'b0, alarm: 1'b0, action: EF_RAMP};
		else
			ext_fault_o <= ef_next;
	end

	// ======================================================================
	// analog reference sample and hold
	always_ff @(posedge clk_i) begin
		if (rst_i || !sh_closed)
			sh_cnt_reg <= 16'h0;
		else if (tick && sh_cnt_reg != 16'(SH_TICKS))
			sh_cnt_reg <= sh_cnt_reg + 16'h1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sh_state_reg <= SH_TRACK;
			held_ref_reg <= 16'h0;
		end else begin
			unique case (sh_state_reg)
				SH_TRACK: begin
					if (sh_closed && sh_cnt_reg == 16'(SH_TICKS)) begin // R5 R6
						held_ref_reg <= ref_selected; // R5
						sh_state_reg <= SH_HELD;
					end
				end
				SH_HELD: begin
					if (!sh_closed)
						sh_state_reg <= SH_TRACK;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			freq_ref_o <= 16'h0;
		else if (sh_state_reg == SH_HELD)
			freq_ref_o <= held_ref_reg; // R5
		else
			freq_ref_o <= ref_selected; // R7
	end

	// ======================================================================
	// energy save voltage ramp
	assign volt_target = es_on ? param_reg[3] : `VOLT_FULL; // R15

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			voltage_level_o <= `VOLT_FULL;
			vrec_cnt_reg    <= 16'h0;
		end else if (voltage_level_o == volt_target) begin
			vrec_cnt_reg <= 16'h0;
		end else if (param_reg[5] == 16'h0) begin
			voltage_level_o <= volt_target;
		end else if (vrec_cnt_reg >= param_reg[5] - 16'h1) begin
			vrec_cnt_reg <= 16'h0;
			if (voltage_level_o < volt_target)
				voltage_level_o <= voltage_level_o + 16'h1; // R16
			else
				voltage_level_o <= voltage_level_o - 16'h1; // R16
		end else begin
			vrec_cnt_reg <= vrec_cnt_reg + 16'h1;
		end
	end

	// ======================================================================
	// inertia ridethrough
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rt_state_reg <= RT_IDLE;
			rt_cnt_reg   <= 16'h0;
		end else begin
			unique case (rt_state_reg)
				RT_IDLE: begin
					rt_cnt_reg <= 16'h0;
					if (rt_sel && power_loss_i)
						rt_state_reg <= RT_ACTIVE; // R17
				end
				RT_ACTIVE: begin
					if (!power_loss_i) begin
						rt_state_reg <= RT_IDLE; // R17
					end else if (rt_cnt_reg >= param_reg[8]) begin
						rt_state_reg <= RT_FAULT; // R17
					end else if (tick) begin
						rt_cnt_reg <= rt_cnt_reg + 16'h1;
					end
				end
				RT_FAULT: begin
					if (!power_loss_i)
						rt_state_reg <= RT_IDLE;
				end
			endcase
		end
	end

	assign bus_product = 32'(param_reg[7]) * `BUS_GAIN_NUM / `BUS_GAIN_DEN; // R18

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ridethrough_o        <= 1'b0;
			undervoltage_fault_o <= 1'b0;
			decel_time_o         <= 16'h0;
			bus_target_o         <= 16'h0;
		end else begin
			ridethrough_o        <= (rt_state_reg == RT_ACTIVE);
			undervoltage_fault_o <= (rt_state_reg == RT_FAULT); // R17
			decel_time_o         <= param_reg[6]; // R17
			bus_target_o         <= bus_product[15:0]; // R18
		end
	end

endmodule : multifunction_input_decoder

// File: verif/contact_bank.sv
// contact switch bank that chatters briefly on every change
`timescale 1ns/1ns
module contact_bank #(
	parameter int N = 8
) (
	input  wire logic         clk_i,
	input  wire logic [N-1:0] want_i,
	output logic      [N-1:0] contacts_o
);
	logic [N-1:0] tgt_reg  = '0;
	logic [N-1:0] prev_reg = '0;
	logic [2:0]   cnt_reg  = '0;

	// ======================================================================
	// chatter between old and new level, then settle
	always_ff @(posedge clk_i) begin
		if (want_i != tgt_reg) begin
			prev_reg <= tgt_reg;
			tgt_reg  <= want_i;
			cnt_reg  <= 3'h4;
		end else if (cnt_reg != 3'h0) begin
			cnt_reg <= cnt_reg - 3'h1;
		end
	end
	assign contacts_o = cnt_reg[0] ? prev_reg : tgt_reg;
endmodule : contact_bank

// File: verif/mfi_chk.sv
// port assertions of the contact input decoder
`timescale 1ns/1ns
module mfi_chk (
	input wire logic clk_i, rst_i, wb_ack_o, running_i, run_cmd_i, jog_cmd_i, power_loss_i,
	input wire logic dc_brake_o, ridethrough_o, undervoltage_fault_o,
	input wire logic [15:0] voltage_level_o,
	input wire mfi_pkg::wb_req_t wb_i,
	input wire mfi_pkg::ext_fault_t ext_fault_o
);
	import mfi_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ======================================================================
	// bus
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
	a_ack_latency: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");

	// ======================================================================
	// controls
	a_brake_yields: assert property (running_i || run_cmd_i || jog_cmd_i |=> !dc_brake_o)
		else $error("brake run");
	a_brake_stopped: assert property ($rose(dc_brake_o) |->
		!$past(running_i) && !$past(run_cmd_i) && !$past(jog_cmd_i)) else $error("brake start");
	a_rt_needs_loss: assert property (!power_loss_i |-> ##2 !ridethrough_o)
		else $error("rt no loss");
	a_rt_start_cause: assert property ($rose(ridethrough_o) |-> $past(power_loss_i, 2))
		else $error("rt start");
	a_uv_needs_loss: assert property (!power_loss_i |-> ##2 !undervoltage_fault_o)
		else $error("uv no loss");
	a_volt_ramp: assert property (!$stable(voltage_level_o) |->
		voltage_level_o - $past(voltage_level_o) == 16'h0001 ||
		$past(voltage_level_o) - voltage_level_o == 16'h0001) else $error("voltage jump");
	a_alarm_action: assert property (ext_fault_o.alarm && !ext_fault_o.fault |->
		ext_fault_o.action == EF_ALARM) else $error("alarm action");
	a_fault_action: assert property (ext_fault_o.fault |-> ext_fault_o.action != EF_ALARM)
		else $error("fault action");

	c_brake: cover property ($rose(dc_brake_o));
	c_ride: cover property ($rose(ridethrough_o));
	c_uv: cover property ($rose(undervoltage_fault_o));
	c_alarm: cover property ($rose(ext_fault_o.alarm));
endmodule : mfi_chk

// File: verif/tb.sv
// testbench of the contact input decoder
`timescale 1ns/1ns
`include "mfi_defines.svh"
module tb;
	import mfi_pkg::*;
	logic        clk_i, rst_i, running_i, run_cmd_i, jog_cmd_i, power_loss_i, wb_ack_o;
	logic        dc_brake_o, ridethrough_o, undervoltage_fault_o, input_setting_error_o;
	logic        lockout_o;
	logic [7:0]  want, contacts_i;
	logic [15:0] analog1_i, analog2_i, out_freq_i, freq_ref_o, voltage_level_o, decel_time_o;
	logic [15:0] bus_target_o;
	logic [31:0] wb_dat_o;
	logic signed [16:0] trim_offset_o;
	wb_req_t     wb_i;
	pid_ctl_t    pid_o;
	ext_fault_t  ext_fault_o;
	int          errors = 0;
	int          comparisons = 0;
	int          cycles = 0;

	contact_bank sw (.clk_i(clk_i), .want_i(want), .contacts_o(contacts_i));
	multifunction_input_decoder #(.TICK_CYCLES(10), .SH_TICKS(5)) dut (.*);

	// ======================================================================
	// shared tasks
	task automatic summarize;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb_rw(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		wb_i <= {1'b1, 1'b1, we, a, 4'hf, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_i <= '0;
	endtask : wb_rw
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb_rw(1'b1, a, d, q);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb_rw(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rd_chk
	task automatic fn(input int i, input logic [7:0] c);
		wr(8'(`OFS_FUNC_BASE + 4 * i), {24'h0, c});
		repeat (3) @(posedge clk_i);
	endtask : fn
	task automatic drive(input logic [7:0] w);
		@(posedge clk_i);
		want <= w;
		repeat (60) @(posedge clk_i);
	endtask : drive

	// ======================================================================
	// scenarios
	task automatic t_reset;
		rd_chk(`OFS_STATUS, 32'h4);
		rd_chk(`OFS_ES_GAIN, 32'h8000);
		rd_chk(`OFS_RT_TIMEOUT, 32'h01f4);
		rd_chk(8'h30, 32'h0);
		chk({16'h0, voltage_level_o}, 32'hffff);
		$display("reset done");
	endtask : t_reset
	task automatic t_pid;
		fn(0, `FN_PID_DISABLE);
		fn(1, `FN_PID_I_RESET);
		fn(2, `FN_PID_I_HOLD);
		drive(8'h07);
		chk({29'h0, pid_o}, 32'h3);
		drive(8'h00);
		chk({29'h0, pid_o}, 32'h4);
		$display("pid done");
	endtask : t_pid
	task automatic t_trim;
		wr(`OFS_TRIM_LEVEL, 32'h0123);
		fn(3, `FN_TRIM_UP);
		drive(8'h08);
		chk({15'h0, trim_offset_o}, 32'h0123);
		wr(`OFS_CONFIG, 32'h1);
		repeat (3) @(posedge clk_i);
		chk({15'h0, trim_offset_o}, 32'h0);
		wr(`OFS_CONFIG, 32'h0);
		fn(3, `FN_TRIM_DOWN);
		chk({15'h0, trim_offset_o}, 32'h1fedd);
		drive(8'h00);
		fn(3, 8'h00);
		$display("trim done");
	endtask : t_trim
	task automatic t_select;
		fn(4, `FN_TERM_SELECT);
		chk({31'h0, input_setting_error_o}, 32'h1);
		wr(`OFS_SECOND_AFN, 32'h1f);
		repeat (3) @(posedge clk_i);
		chk({31'h0, input_setting_error_o}, 32'h0);
		chk({16'h0, freq_ref_o}, 32'h1111);
		drive(8'h10);
		chk({16'h0, freq_ref_o}, 32'h2222);
		drive(8'h00);
		fn(4, 8'h00);
		$display("select done");
	endtask : t_select
	task automatic t_hold;
		fn(5, `FN_SAMPLE_HOLD);
		@(posedge clk_i);
		want <= 8'h20;
		repeat (31) @(posedge clk_i);
		want <= 8'h00;
		repeat (60) @(posedge clk_i);
		analog1_i <= 16'h3333;
		repeat (4) @(posedge clk_i);
		chk({16'h0, freq_ref_o}, 32'h3333);
		drive(8'h20);
		repeat (100) @(posedge clk_i);
		analog1_i <= 16'h4444;
		repeat (4) @(posedge clk_i);
		chk({16'h0, freq_ref_o}, 32'h3333);
		drive(8'h00);
		chk({16'h0, freq_ref_o}, 32'h4444);
		fn(5, 8'h00);
		$display("hold done");
	endtask : t_hold
	task automatic t_fault;
		int k;
		logic [7:0] c;
		logic a;
		for (k = 0; k < 64; k++) begin
			c = 8'h20 | 8'(k[3:0]);
			fn(6, c);
			@(posedge clk_i);
			running_i <= k[5];
			want <= {1'b0, k[4], 6'h0};
			repeat (60) @(posedge clk_i);
			a = (k[4] ^ c[0]) && (!c[1] || k[5]);
			chk({30'h0, ext_fault_o.fault, ext_fault_o.alarm},
				{30'h0, a && c[3:2] != 2'b11, a && c[3:2] == 2'b11});
			if (a) chk({30'h0, ext_fault_o.action}, {30'h0, c[3:2]});
		end
		fn(6, 8'h00);
		running_i <= 1'b0;
		drive(8'h00);
		$display("fault done");
	endtask : t_fault
	task automatic t_brake;
		fn(0, `FN_DC_BRAKE);
		@(posedge clk_i);
		want <= 8'h01;
		repeat (5) @(posedge clk_i);
		want <= 8'h00;
		repeat (60) @(posedge clk_i);
		chk({31'h0, dc_brake_o}, 32'h0);
		drive(8'h01);
		chk({31'h0, dc_brake_o}, 32'h1);
		run_cmd_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk({31'h0, dc_brake_o}, 32'h0);
		run_cmd_i <= 1'b0;
		jog_cmd_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk({31'h0, dc_brake_o}, 32'h0);
		jog_cmd_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk({31'h0, dc_brake_o}, 32'h1);
		fn(0, 8'h61);
		rd_chk(`OFS_STATUS, 32'h00010004);
		drive(8'h00);
		$display("brake done");
	endtask : t_brake
	task automatic t_energy;
		wr(`OFS_ES_GAIN, 32'hfff0);
		wr(`OFS_ES_START, 32'h0100);
		fn(1, `FN_ENERGY_SAVE);
		drive(8'h02);
		chk({16'h0, voltage_level_o}, 32'hffff);
		out_freq_i <= 16'h0200;
		repeat (40) @(posedge clk_i);
		chk({16'h0, voltage_level_o}, 32'hfff0);
		drive(8'h00);
		chk({16'h0, voltage_level_o}, 32'hffff);
		fn(1, 8'h00);
		$display("energy done");
	endtask : t_energy
	task automatic t_ride;
		wr(`OFS_INPUT_VOLT, 32'h0064);
		wr(`OFS_FAST_STOP, 32'h0123);
		wr(`OFS_RT_TIMEOUT, 32'h3);
		fn(2, `FN_RT_NO);
		drive(8'h04);
		chk({16'h0, bus_target_o}, 32'h0087);
		chk({16'h0, decel_time_o}, 32'h0123);
		power_loss_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk({31'h0, ridethrough_o}, 32'h1);
		power_loss_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk({31'h0, ridethrough_o}, 32'h0);
		power_loss_i <= 1'b1;
		repeat (60) @(posedge clk_i);
		chk({31'h0, undervoltage_fault_o}, 32'h1);
		power_loss_i <= 1'b0;
		fn(2, `FN_RT_NC);
		chk({31'h0, undervoltage_fault_o}, 32'h0);
		drive(8'h00);
		power_loss_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk({31'h0, ridethrough_o}, 32'h1);
		power_loss_i <= 1'b0;
		fn(2, 8'h00);
		$display("ride done");
	endtask : t_ride
	task automatic t_lock;
		fn(7, `FN_LOCKOUT);
		chk({31'h0, lockout_o}, 32'h1);
		wr(`OFS_TRIM_LEVEL, 32'h0555);
		rd_chk(`OFS_TRIM_LEVEL, 32'h0123);
		drive(8'h80);
		wr(`OFS_TRIM_LEVEL, 32'h0555);
		rd_chk(`OFS_TRIM_LEVEL, 32'h0555);
		$display("lock done");
	endtask : t_lock

	// ======================================================================
	// clock, timeout and main sequence
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			summarize();
		end
	end
	initial begin
		rst_i = 1'b1;
		wb_i = '0;
		want = 8'h00;
		analog1_i = 16'h1111;
		analog2_i = 16'h2222;
		out_freq_i = 16'h0080;
		{running_i, run_cmd_i, jog_cmd_i, power_loss_i} = 4'h0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_pid();
		t_trim();
		t_select();
		t_hold();
		t_fault();
		t_brake();
		t_energy();
		t_ride();
		t_lock();
		summarize();
	end
endmodule : tb

bind multifunction_input_decoder mfi_chk chk (.*);
